// ---- supervisor_fault_log_defs.vh ----
`ifndef SUPERVISOR_FAULT_LOG_DEFS_VH
`define SUPERVISOR_FAULT_LOG_DEFS_VH

// Command codes
`define CMD_FAULT_LOG 8'h11
`define CMD_PAD_LEVELS 8'h1A
`define CMD_LOG_CLEAR 8'h1B
`define CMD_NV_SAVE 8'h1C
`define CMD_NV_LOAD 8'h1D
`define CMD_NV_SNAPSHOT 8'h1E
`define CMD_LIVE_FAULT 8'h1F

// Operating settings word layout
`define SET_W 19
`define SET_UPOL_LSB 0
`define SET_LPOL_LSB 6
`define SET_IN1_FUNC_LSB 12
`define SET_IN2_FUNC_LSB 15
`define SET_RCL_BIT 18
`define SET_DEFAULT 19'h0_003F

// General input function codes
`define FUNC_MANUAL_RESET 3'h1
`define FUNC_SUPPLY_TRIM 3'h2
`define FUNC_UNDERVOLT_INH 3'h3

// Timing at 100 MHz: 10 ms log clear, 200 us NV transaction
`define CLEAR_CYCLES_DEF 20'hF_4240
`define NV_CYCLES_DEF 20'h0_4E20
`define BUSY_CNT_W 20

`endif

// ---- fault_channel.v ----
module fault_channel (
  input wire core_clk,
  input wire rst_n,
  input wire above_upper,
  input wire above_lower,
  input wire upper_pol,
  input wire lower_pol,
  input wire trim_act,
  input wire uvinh_act,
  input wire log_clr,
  input wire hold_clr,
  output wire upper_fault,
  output wire lower_fault,
  output reg upper_latched_ff,
  output reg lower_latched_ff,
  output reg hold_ff
);
  wire upper_raw;
  wire lower_raw;
  wire nxt_upper;
  wire nxt_lower;
  wire nxt_hold;

  assign upper_raw = upper_pol ? above_upper : ~above_upper;
  assign lower_raw = lower_pol ? above_lower : ~above_lower;
  // Polarity 0 means an undervoltage-type comparator
  assign upper_fault = upper_raw & ~trim_act & ~(uvinh_act & ~upper_pol);
  assign lower_fault = lower_raw & ~trim_act & ~(uvinh_act & ~lower_pol);

  // A fault present in the clearing cycle survives the clear
  assign nxt_upper = (upper_latched_ff & ~log_clr) | upper_fault;
  assign nxt_lower = (lower_latched_ff & ~log_clr) | lower_fault;
  assign nxt_hold = (hold_ff & ~hold_clr) | upper_fault | lower_fault;

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      upper_latched_ff <= 1'b0;
      lower_latched_ff <= 1'b0;
      hold_ff <= 1'b0;
    end else begin
      upper_latched_ff <= nxt_upper;
      lower_latched_ff <= nxt_lower;
      hold_ff <= nxt_hold;
    end
  end
endmodule

// ---- supervisor_fault_log_regs.v ----
`include "supervisor_fault_log_defs.vh"

// Notes on behaviour
// - Command 0x11 returns 16-bit fault log
// - Log bits set by faults, sticky
// - Log pairs channel upper/lower, bits 12..1
// - Command 0x1A returns pad levels
// - Pad bit follows pin logic level
// - Command 0x1B clears all log bits except those with a fault present that cycle
// - Manual reset clears log when enabled
// - Log clear leaves live snapshot alone
// - Clear busy about 10ms, no acknowledge
// - 0x1C saves settings, 0x1D reloads them
// - Power-up loads NV settings automatically, but the NV store resets with the core, so this loads defaults
// - First fault copies log to backup
// - Further backups blocked until log clear; only command 0x1B re-arms here, a manual-reset log clear does not
// - Command 0x1F returns live unlatched snapshot
// - Trim or inhibit inputs suppress snapshot faults
// - Snapshot pairs channel upper/lower, descending
// - Polarity selects above or below threshold
// - Upper polarity defaults 1, lower 0
// - Supply trim low ignores all faults
// - Undervolt inhibit low ignores undervoltage faults
// - Log read or clear drops alert
// - Manual reset or clear releases hold
module supervisor_fault_log_regs #(
  parameter [`BUSY_CNT_W-1:0] CLEAR_CYCLES = `CLEAR_CYCLES_DEF,
  parameter [`BUSY_CNT_W-1:0] NV_CYCLES = `NV_CYCLES_DEF
) (
  input wire core_clk,
  input wire nrst,
  input wire cmd_valid,
  input wire [7:0] cmd_code,
  output wire cmd_ready,
  output reg [15:0] rd_data_ff,
  output reg rd_valid_ff,
  input wire cfg_wr,
  input wire [`SET_W-1:0] cfg_wdata,
  output wire [`SET_W-1:0] cfg_rdata,
  input wire [5:0] above_upper,
  input wire [5:0] above_lower,
  input wire [1:0] general_input,
  input wire [2:0] general_io,
  input wire [5:0] comparator_out,
  output wire [5:0] cmp_hold,
  output reg alert_pending_ff
);
  localparam [1:0] ST_BOOT = 2'b00;
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_BUSY = 2'b10;

  reg rst_meta_ff;
  reg rst_n_ff;
  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [`BUSY_CNT_W-1:0] busy_cnt_ff;
  reg [`BUSY_CNT_W-1:0] nxt_busy_cnt;
  reg [`SET_W-1:0] settings_ff;
  reg [`SET_W-1:0] nxt_settings;
  reg [`SET_W-1:0] nv_settings_ff;
  reg [`SET_W-1:0] nxt_nv_settings;
  reg [15:0] nv_backup_ff;
  reg [15:0] nxt_nv_backup;
  reg [15:0] backup_copy_ff;
  reg [15:0] nxt_backup_copy;
  reg backup_armed_ff;
  reg nxt_backup_armed;
  reg [15:0] nxt_rd_data;
  reg nxt_rd_valid;
  reg nxt_alert;

  wire cmd_take;
  wire [5:0] upper_fault;
  wire [5:0] lower_fault;
  wire [5:0] upper_latched;
  wire [5:0] lower_latched;
  wire [15:0] log_word;
  wire [15:0] live_word;
  wire [15:0] pad_word;
  wire [2:0] in1_func;
  wire [2:0] in2_func;
  wire trim_act;
  wire uvinh_act;
  wire man_reset_act;
  wire clear_cmd;
  wire log_clr;
  wire hold_clr;
  wire any_fault;
  wire backup_fire;

  // Reset release through two stages
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff <= rst_meta_ff;
    end
  end

  assign in1_func = settings_ff[`SET_IN1_FUNC_LSB +: 3];
  assign in2_func = settings_ff[`SET_IN2_FUNC_LSB +: 3];

  // The general inputs are active low in every function
  assign trim_act = ((in1_func == `FUNC_SUPPLY_TRIM) & ~general_input[0]) |
                    ((in2_func == `FUNC_SUPPLY_TRIM) & ~general_input[1]);
  assign uvinh_act = ((in1_func == `FUNC_UNDERVOLT_INH) & ~general_input[0]) |
                     ((in2_func == `FUNC_UNDERVOLT_INH) & ~general_input[1]);
  assign man_reset_act = ((in1_func == `FUNC_MANUAL_RESET) & ~general_input[0]) |
                  ((in2_func == `FUNC_MANUAL_RESET) & ~general_input[1]);

  // Busy covers clear processing and every NV transaction
  assign cmd_ready = (state_ff == ST_IDLE);
  assign cmd_take = cmd_valid & cmd_ready;
  assign clear_cmd = cmd_take & (cmd_code == `CMD_LOG_CLEAR);
  assign log_clr = clear_cmd | (man_reset_act & settings_ff[`SET_RCL_BIT]);
  assign hold_clr = clear_cmd | man_reset_act;

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_chan
      fault_channel u_chan (
        .core_clk(core_clk),
        .rst_n(rst_n_ff),
        .above_upper(above_upper[gi]),
        .above_lower(above_lower[gi]),
        .upper_pol(settings_ff[`SET_UPOL_LSB + gi]),
        .lower_pol(settings_ff[`SET_LPOL_LSB + gi]),
        .trim_act(trim_act),
        .uvinh_act(uvinh_act),
        .log_clr(log_clr),
        .hold_clr(hold_clr),
        .upper_fault(upper_fault[gi]),
        .lower_fault(lower_fault[gi]),
        .upper_latched_ff(upper_latched[gi]),
        .lower_latched_ff(lower_latched[gi]),
        .hold_ff(cmp_hold[gi])
      );
      assign log_word[2*gi+2] = upper_latched[gi];
      assign log_word[2*gi+1] = lower_latched[gi];
      assign live_word[2*gi+2] = upper_fault[gi];
      assign live_word[2*gi+1] = lower_fault[gi];
    end
  endgenerate

  assign log_word[15:13] = 3'h0;
  assign log_word[0] = 1'b0;
  assign live_word[15:13] = 3'h0;
  assign live_word[0] = 1'b0;
  assign pad_word = {5'h00, general_input[1], general_input[0], general_io[2:0], comparator_out[5:0]};

  assign any_fault = |live_word;
  // Only the first fault after arming lands in NV; later ones do not overwrite it until a 0x1B clear command re-arms
  assign backup_fire = backup_armed_ff & any_fault & (state_ff != ST_BOOT);
  assign cfg_rdata = settings_ff;

  always @* begin
    nxt_state = state_ff;
    nxt_busy_cnt = busy_cnt_ff;
    nxt_settings = settings_ff;
    nxt_nv_settings = nv_settings_ff;
    nxt_nv_backup = nv_backup_ff;
    nxt_backup_copy = backup_copy_ff;
    nxt_backup_armed = backup_armed_ff;
    nxt_rd_data = rd_data_ff;
    nxt_rd_valid = 1'b0;
    nxt_alert = alert_pending_ff;
    if (cfg_wr && state_ff == ST_IDLE) begin
      nxt_settings = cfg_wdata;
    end
    case (state_ff)
      ST_BOOT: begin
        nxt_settings = nv_settings_ff;
        nxt_backup_copy = nv_backup_ff;
        nxt_busy_cnt = NV_CYCLES;
        nxt_state = ST_BUSY;
      end
      ST_IDLE: begin
        if (cmd_take) begin
          case (cmd_code)
            `CMD_FAULT_LOG: begin
              nxt_rd_data = log_word;
              nxt_rd_valid = 1'b1;
            end
            `CMD_PAD_LEVELS: begin
              nxt_rd_data = pad_word;
              nxt_rd_valid = 1'b1;
            end
            `CMD_NV_SNAPSHOT: begin
              nxt_rd_data = backup_copy_ff;
              nxt_rd_valid = 1'b1;
            end
            `CMD_LIVE_FAULT: begin
              nxt_rd_data = live_word;
              nxt_rd_valid = 1'b1;
            end
            `CMD_LOG_CLEAR: begin
              nxt_backup_armed = 1'b1;
              nxt_busy_cnt = CLEAR_CYCLES;
              nxt_state = ST_BUSY;
            end
            `CMD_NV_SAVE: begin
              nxt_nv_settings = settings_ff;
              nxt_nv_backup = log_word;
              nxt_busy_cnt = NV_CYCLES;
              nxt_state = ST_BUSY;
            end
            `CMD_NV_LOAD: begin
              nxt_settings = nv_settings_ff;
              nxt_backup_copy = nv_backup_ff;
              nxt_busy_cnt = NV_CYCLES;
              nxt_state = ST_BUSY;
            end
            default: begin
              nxt_rd_valid = 1'b0;
            end
          endcase
        end
      end
      ST_BUSY: begin
        if (busy_cnt_ff <= {{(`BUSY_CNT_W-1){1'b0}}, 1'b1}) begin
          nxt_busy_cnt = {`BUSY_CNT_W{1'b0}};
          nxt_state = ST_IDLE;
        end else begin
          nxt_busy_cnt = busy_cnt_ff - 1'b1;
        end
      end
      default: begin
        nxt_state = ST_BOOT;
      end
    endcase
    // Backup write rides on whatever busy period is running
    if (backup_fire && !clear_cmd) begin
      nxt_nv_backup = log_word | live_word;
      nxt_backup_armed = 1'b0;
      if (nxt_state == ST_IDLE) begin
        nxt_busy_cnt = NV_CYCLES;
        nxt_state = ST_BUSY;
      end
    end
    // Alert drops on log read or clear unless a fault persists; new fault wins
    if (cmd_take && (cmd_code == `CMD_FAULT_LOG || cmd_code == `CMD_LOG_CLEAR)) begin
      nxt_alert = 1'b0;
    end
    if (any_fault) begin
      nxt_alert = 1'b1;
    end
  end

  always @(posedge core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      state_ff <= ST_BOOT;
      busy_cnt_ff <= {`BUSY_CNT_W{1'b0}};
      settings_ff <= `SET_DEFAULT;
      backup_copy_ff <= 16'h0000;
      backup_armed_ff <= 1'b1;
      rd_data_ff <= 16'h0000;
      rd_valid_ff <= 1'b0;
      alert_pending_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      busy_cnt_ff <= nxt_busy_cnt;
      settings_ff <= nxt_settings;
      backup_copy_ff <= nxt_backup_copy;
      backup_armed_ff <= nxt_backup_armed;
      rd_data_ff <= nxt_rd_data;
      rd_valid_ff <= nxt_rd_valid;
      alert_pending_ff <= nxt_alert;
    end
  end

  // Nonvolatile store: reset by rst_n_ff like the core registers, so contents do not survive a core reset
  always @(posedge core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      nv_settings_ff <= `SET_DEFAULT;
      nv_backup_ff <= 16'h0000;
    end else begin
      nv_settings_ff <= nxt_nv_settings;
      nv_backup_ff <= nxt_nv_backup;
    end
  end
endmodule

// ---- supervisor_fault_log_regs_assertions.sv ----
`include "supervisor_fault_log_defs.vh"
module fault_log_checker #(
  parameter [`BUSY_CNT_W-1:0] CLEAR_CYCLES = `CLEAR_CYCLES_DEF,
  parameter [`BUSY_CNT_W-1:0] NV_CYCLES = `NV_CYCLES_DEF
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic cmd_ready,
  input wire logic [15:0] rd_data_ff,
  input wire logic rd_valid_ff,
  input wire logic [`SET_W-1:0] cfg_rdata,
  input wire logic [5:0] above_upper,
  input wire logic [5:0] above_lower,
  input wire logic [1:0] general_input,
  input wire logic [5:0] cmp_hold,
  input wire logic alert_pending_ff
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] rs_ff;
  logic [`BUSY_CNT_W-1:0] low_cnt_ff;
  logic [1:0] mode_ff;
  logic trim;
  logic inh;
  logic [15:0] live;
  wire take = cmd_valid && cmd_ready;
  wire rd_take = take && (cmd_code == 8'h11 || cmd_code == 8'h1A || cmd_code == 8'h1E || cmd_code == 8'h1F);
  // One stage later than the design's sync, so boot cycles are never judged
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rs_ff <= 3'h0;
      low_cnt_ff <= '0;
      mode_ff <= 2'h0;
    end else begin
      rs_ff <= {rs_ff[1:0], 1'b1};
      low_cnt_ff <= cmd_ready ? '0 : low_cnt_ff + 1'b1;
      mode_ff <= !take ? mode_ff : cmd_code == 8'h1B ? 2'h1 : (cmd_code == 8'h1C || cmd_code == 8'h1D) ? 2'h2 : 2'h0;
    end
  end
  always_comb begin
    trim = (cfg_rdata[14:12] == `FUNC_SUPPLY_TRIM && !general_input[0]) || (cfg_rdata[17:15] == `FUNC_SUPPLY_TRIM && !general_input[1]);
    inh = (cfg_rdata[14:12] == `FUNC_UNDERVOLT_INH && !general_input[0]) || (cfg_rdata[17:15] == `FUNC_UNDERVOLT_INH && !general_input[1]);
    live = 16'h0000;
    for (int i = 0; i < 6; i++) begin
      live[2*i+2] = !trim && (cfg_rdata[i] ? above_upper[i] : !above_upper[i] && !inh);
      live[2*i+1] = !trim && (cfg_rdata[6+i] ? above_lower[i] : !above_lower[i] && !inh);
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rs_ff[2]);
  chk_read_answer: assert property (rd_take |=> rd_valid_ff)
    else $error("read not answered");
  chk_quiet_valid: assert property (!rd_take |=> !rd_valid_ff)
    else $error("answer without a taken read");
  chk_busy_time: assert property ($rose(cmd_ready) && mode_ff != 2'h0 |-> low_cnt_ff == (mode_ff == 2'h1 ? CLEAR_CYCLES : NV_CYCLES))
    else $error("busy length wrong");
  chk_clear_drops: assert property (take && cmd_code == 8'h1B |=> !cmd_ready [*4])
    else $error("ready during clear");
  chk_reserved_zero: assert property (rd_valid_ff |-> rd_data_ff[15:13] == 3'h0)
    else $error("reserved bits set");
  chk_live_word: assert property (take && cmd_code == 8'h1F |=> rd_data_ff == $past(live))
    else $error("live word wrong");
  chk_alert_set: assert property (|live |=> alert_pending_ff)
    else $error("alert not raised");
  chk_alert_clear: assert property (take && cmd_code == 8'h11 && live == 16'h0000 |=> !alert_pending_ff)
    else $error("alert not dropped");
  chk_hold_clear: assert property (take && cmd_code == 8'h1B && live == 16'h0000 |=> cmp_hold == 6'h00)
    else $error("hold not released");
  cov_clear: cover property (take && cmd_code == 8'h1B);
  cov_live: cover property (take && cmd_code == 8'h1F && |live);
  cov_alert: cover property ($rose(alert_pending_ff));
endmodule

bind supervisor_fault_log_regs fault_log_checker #(.CLEAR_CYCLES(CLEAR_CYCLES), .NV_CYCLES(NV_CYCLES)) fault_log_checker_inst (
  .core_clk, .nrst, .cmd_valid, .cmd_code, .cmd_ready, .rd_data_ff, .rd_valid_ff, .cfg_rdata,
  .above_upper, .above_lower, .general_input, .cmp_hold, .alert_pending_ff);

// ---- fault_log_host.sv ----
module fault_log_host (
  input wire logic core_clk,
  input wire logic cmd_ready,
  input wire logic rd_valid_ff,
  input wire logic [15:0] rd_data_ff,
  output logic cmd_valid,
  output logic [7:0] cmd_code
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cmd_valid = 1'b0;
    cmd_code = 8'h00;
  end
  // Ready only changes on a rising edge, so the falling edge sees what the next rise samples
  task automatic send(input logic [7:0] code, output logic ok, output logic [16:0] ans);
    ok = 1'b0;
    @(negedge core_clk);
    cmd_valid = 1'b1;
    cmd_code = code;
    for (int n = 0; n < 40 && !ok; n++) begin
      if (cmd_ready) ok = 1'b1;
      else @(negedge core_clk);
    end
    @(negedge core_clk);
    ans = {rd_valid_ff, rd_data_ff};
    cmd_valid = 1'b0;
    cmd_code = ~code;
  endtask
endmodule

// ---- tb.sv ----
`define check_eq(what, exp, got) begin cmp_count++; if ((got) !== (exp)) begin failures++; \
  $display("Error %s expected %h seen %h", what, exp, got); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic cfg_wr = 1'b0;
  logic [18:0] cfg_wdata = 19'h0_0000;
  logic [5:0] above_upper = 6'h00;
  logic [5:0] above_lower = 6'h3F;
  logic [1:0] general_input = 2'h3;
  logic [2:0] general_io = 3'h0;
  logic [5:0] comparator_out = 6'h00;
  wire cmd_valid, cmd_ready, rd_valid_ff, alert_pending_ff;
  wire [7:0] cmd_code;
  wire [15:0] rd_data_ff;
  wire [18:0] cfg_rdata;
  wire [5:0] cmp_hold;
  int failures = 0;
  int cmp_count = 0;
  logic ok;
  logic [16:0] ans;
  logic [10:0] pat [2] = '{11'h56A, 11'h295};
  supervisor_fault_log_regs #(.CLEAR_CYCLES(20'h0_0008), .NV_CYCLES(20'h0_0004)) supervisor_fault_log_regs_inst (
    .core_clk, .nrst, .cmd_valid, .cmd_code, .cmd_ready, .rd_data_ff, .rd_valid_ff, .cfg_wr, .cfg_wdata, .cfg_rdata,
    .above_upper, .above_lower, .general_input, .general_io, .comparator_out, .cmp_hold, .alert_pending_ff);
  fault_log_host fault_log_host_inst (.core_clk, .cmd_ready, .rd_valid_ff, .rd_data_ff, .cmd_valid, .cmd_code);
  always #5 core_clk = ~core_clk;
  task automatic complete_run;
    $display("Comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cmd(input logic [7:0] c);
    fault_log_host_inst.send(c, ok, ans);
    if (!ok) begin
      failures++;
      complete_run();
    end
  endtask
  task automatic set_cfg(input logic [18:0] v);
    for (int n = 0; n < 40 && !cmd_ready; n++) @(negedge core_clk);
    if (cmd_ready !== 1'b1) begin
      failures++;
      complete_run();
    end
    cfg_wdata = v;
    cfg_wr = 1'b1;
    @(negedge core_clk);
    cfg_wr = 1'b0;
    `check_eq("settings", v, cfg_rdata)
  endtask
  task automatic t_boot_pads;
    cmd(8'h1F);
    `check_eq("live", 17'h1_0000, ans)
    `check_eq("settings", 19'h0_003F, cfg_rdata)
    for (int k = 0; k < 2; k++) begin
      {general_input, general_io, comparator_out} = pat[k];
      cmd(8'h1A);
      `check_eq("pads", {1'b1, 5'h00, pat[k]}, ans)
    end
    general_input = 2'h3;
    // A code outside the map is taken but never answered
    cmd(8'h00);
    `check_eq("no answer", 1'b0, ans[16])
  endtask
  task automatic t_log_backup;
    above_upper = 6'h01;
    above_lower = 6'h1F;
    cmd(8'h1F);
    `check_eq("live", 17'h1_0804, ans)
    `check_eq("alert", 1'b1, alert_pending_ff)
    above_upper = 6'h00;
    above_lower = 6'h3F;
    cmd(8'h11);
    `check_eq("log", 17'h1_0804, ans)
    `check_eq("alert", 1'b0, alert_pending_ff)
    above_upper = 6'h04;
    cmd(8'h1F);
    `check_eq("live", 17'h1_0040, ans)
    above_upper = 6'h00;
    cmd(8'h1D);
    cmd(8'h1E);
    `check_eq("backup", 17'h1_0804, ans)
  endtask
  task automatic t_clear;
    above_lower = 6'h3D;
    cmd(8'h1B);
    `check_eq("ready", 1'b0, cmd_ready)
    cmd(8'h1F);
    `check_eq("live", 17'h1_0008, ans)
    above_lower = 6'h3F;
    cmd(8'h1B);
    cmd(8'h11);
    `check_eq("log", 17'h1_0000, ans)
    cmd(8'h1C);
    cmd(8'h1D);
    cmd(8'h1E);
    `check_eq("backup", 17'h1_0000, ans)
  endtask
  task automatic t_inputs;
    set_cfg(19'h5_A03E);
    above_upper = 6'h02;
    cmd(8'h1F);
    `check_eq("live", 17'h1_0014, ans)
    general_input = 2'h1;
    cmd(8'h1F);
    `check_eq("live", 17'h1_0010, ans)
    general_input = 2'h2;
    cmd(8'h1F);
    `check_eq("live", 17'h1_0000, ans)
    general_input = 2'h3;
    `check_eq("hold", 6'h03, cmp_hold)
    set_cfg(19'h5_903E);
    above_upper = 6'h01;
    general_input = 2'h2;
    cmd(8'h11);
    `check_eq("log", 17'h1_0000, ans)
    `check_eq("hold", 6'h00, cmp_hold)
    general_input = 2'h3;
    // Functions swapped between the two inputs
    set_cfg(19'h1_303E);
    above_upper = 6'h02;
    general_input = 2'h2;
    cmd(8'h1F);
    `check_eq("live", 17'h1_0010, ans)
    general_input = 2'h1;
    cmd(8'h1F);
    `check_eq("live", 17'h1_0000, ans)
    general_input = 2'h3;
    // Manual reset without the clear option keeps the log
    set_cfg(19'h1_903E);
    above_upper = 6'h01;
    general_input = 2'h2;
    cmd(8'h11);
    `check_eq("log", 17'h1_0014, ans)
    `check_eq("hold", 6'h00, cmp_hold)
    general_input = 2'h3;
  endtask
  initial begin
    repeat (2) @(negedge core_clk);
    nrst = 1'b1;
    t_boot_pads();
    t_log_backup();
    t_clear();
    t_inputs();
    complete_run();
  end
endmodule
